// ### include/eeb_pkg.sv
package eeb_pkg;
  // clock period in picoseconds (200 MHz)
  localparam longint CLK_PERIOD_PS = 5000;
  // power_up_settle_interval: least time, in microseconds
  localparam longint SETTLE_TIME_US = 70;
  // internal_write_duration: longest time, in milliseconds
  localparam longint WRITE_TIME_MS = 5;
  // least time rounds up
  localparam int SETTLE_CYCLES =
    int'((SETTLE_TIME_US * 64'd1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // longest time rounds down
  localparam int WRITE_CYCLES = int'((WRITE_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS);
  localparam int TIMER_W = 20;
  localparam logic [TIMER_W-1:0] TIMER_RST = 20'h00000;
  // device type field of the select word; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
  localparam int WORD_BITS = 8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] SHIFT_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_INIT  = 4'h0,
    ST_IDLE  = 4'h1,
    ST_ADDR  = 4'h2,
    ST_ACK   = 4'h3,
    ST_RX    = 4'h4,
    ST_TX    = 4'h5,
    ST_TXACK = 4'h6,
    ST_SKIP  = 4'h7,
    ST_BUSY  = 4'h8
  } eeb_state_t;
endpackage : eeb_pkg

// ### core/eeb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module eeb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  // storage count excludes the output register, so full is exact
  wire full = (count_q == (AW+1)'(DEPTH));
  wire empty = (count_q == '0);
  wire push = in_valid_in & ~full;
  wire pop = ~empty & (~out_valid_q | out_ready_in);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_in;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        out_data_q <= mem_q[rd_ptr_q];
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_valid_q <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_q <= 1'b0;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  assign in_ready_out = ~full;
  assign out_valid_out = out_valid_q;
  assign out_data_out = out_data_q;
endmodule : eeb_fifo
`default_nettype wire

// ### core/eeb_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module eeb_front_end
  import eeb_pkg::*;
#(
  parameter int SETTLE_CYC = eeb_pkg::SETTLE_CYCLES,
  parameter int WRITE_CYC = eeb_pkg::WRITE_CYCLES,
  parameter logic [3:0] DEV_TYPE = eeb_pkg::DEV_TYPE_DEFAULT
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic addr_strap_bit2_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit0_in,
  output logic [eeb_pkg::FIFO_WIDTH-1:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic [7:0] rd_data_in,
  output logic rd_req_out,
  output logic standby_out,
  output logic write_busy_out
);
  import eeb_pkg::*;

  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [2:0] strap_s1, strap_s2;
  eeb_state_t state_q;
  logic [TIMER_W-1:0] timer_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic oe_n_q;
  logic rw_q;
  logic first_q;
  logic wr_seen_q;
  logic push_q;
  logic [FIFO_WIDTH-1:0] push_data_q;
  logic rd_req_q;
  logic standby_q;
  logic busy_q;
  logic sda_drv_q;
  logic fifo_ready;

  function automatic logic [TIMER_W-1:0] last_tick(input int cycles);
    last_tick = TIMER_W'(cycles - 1);
  endfunction : last_tick

  // edge detection reads only the second and third stages
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire word_done = scl_fall & (cnt_q == BIT_CNT_FULL);
  wire [7:0] shift_d = {shift_q[6:0], sda_s2};
  wire addr_match = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == strap_s2);
  wire bus_live = (state_q != ST_INIT) && (state_q != ST_BUSY);
  wire settle_done = (timer_q == last_tick(SETTLE_CYC));
  wire write_done = (timer_q == last_tick(WRITE_CYC));

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      strap_s1 <= {addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in};
      strap_s2 <= strap_s1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= ST_INIT;
      timer_q <= TIMER_RST;
      cnt_q <= BIT_CNT_RST;
      shift_q <= SHIFT_RST;
      tx_q <= SHIFT_RST;
      oe_n_q <= 1'b1;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      wr_seen_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= '0;
      rd_req_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      rd_req_q <= 1'b0;
      unique case (state_q)
        ST_INIT: begin
          timer_q <= timer_q + 1'b1;
          if (settle_done) begin
            state_q <= ST_IDLE;
            timer_q <= TIMER_RST;
          end
        end
        ST_BUSY: begin
          timer_q <= timer_q + 1'b1;
          if (write_done) begin
            state_q <= ST_IDLE;
            timer_q <= TIMER_RST;
          end
        end
        default: begin
          if (start_det) begin
            state_q <= ST_ADDR;
            cnt_q <= BIT_CNT_RST;
            oe_n_q <= 1'b1;
            wr_seen_q <= 1'b0;
          end else if (stop_det) begin
            oe_n_q <= 1'b1;
            wr_seen_q <= 1'b0;
            if (wr_seen_q) begin
              state_q <= ST_BUSY;
              timer_q <= TIMER_RST;
            end else begin
              state_q <= ST_IDLE;
            end
          end else begin
            unique case (state_q)
              ST_ADDR, ST_RX: begin
                if (scl_rise) begin
                  shift_q <= shift_d;
                  cnt_q <= cnt_q + 1'b1;
                end else if (word_done) begin
                  if (state_q == ST_ADDR && !addr_match) begin
                    state_q <= ST_IDLE;
                  end else if (state_q == ST_ADDR) begin
                    oe_n_q <= 1'b0;
                    rw_q <= shift_q[0];
                    first_q <= 1'b1;
                    state_q <= ST_ACK;
                  end else if (fifo_ready) begin
                    // full buffer refuses the word by leaving it unacknowledged
                    oe_n_q <= 1'b0;
                    push_q <= 1'b1;
                    push_data_q <= {first_q, shift_q};
                    wr_seen_q <= wr_seen_q | ~first_q;
                    first_q <= 1'b0;
                    state_q <= ST_ACK;
                  end else begin
                    state_q <= ST_SKIP;
                  end
                end
              end
              ST_ACK: begin
                if (scl_fall) begin
                  cnt_q <= BIT_CNT_RST;
                  if (rw_q) begin
                    tx_q <= rd_data_in;
                    oe_n_q <= rd_data_in[7];
                    rd_req_q <= 1'b1;
                    state_q <= ST_TX;
                  end else begin
                    oe_n_q <= 1'b1;
                    state_q <= ST_RX;
                  end
                end
              end
              ST_TX: begin
                if (scl_rise) begin
                  cnt_q <= cnt_q + 1'b1;
                end else if (word_done) begin
                  oe_n_q <= 1'b1;
                  state_q <= ST_TXACK;
                end else if (scl_fall) begin
                  oe_n_q <= tx_q[6];
                  tx_q <= {tx_q[6:0], 1'b0};
                end
              end
              ST_TXACK: begin
                if (scl_rise && sda_s2) begin
                  state_q <= ST_SKIP;
                end else if (scl_fall) begin
                  cnt_q <= BIT_CNT_RST;
                  tx_q <= rd_data_in;
                  oe_n_q <= rd_data_in[7];
                  rd_req_q <= 1'b1;
                  state_q <= ST_TX;
                end
              end
              default: begin
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      standby_q <= 1'b0;
      busy_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else begin
      standby_q <= (state_q == ST_IDLE);
      busy_q <= (state_q == ST_BUSY);
      sda_drv_q <= 1'b0;
    end
  end

  eeb_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .in_valid_in(push_q),
    .in_ready_out(fifo_ready),
    .in_data_in(push_data_q),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in),
    .out_data_out(rx_data_out)
  );

  assign sda_out = sda_drv_q;
  assign sda_oe_n_out = oe_n_q;
  assign rd_req_out = rd_req_q;
  assign standby_out = standby_q;
  assign write_busy_out = busy_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  chk_drive_on_low: assert property (
    $fell(oe_n_q) |-> !$past(scl_s2)
  ) else $error("data line driven low while clock high");

  chk_start_to_addr: assert property (
    start_det && bus_live |=> state_q == ST_ADDR && oe_n_q
  ) else $error("start not taken");

  chk_stop_ends: assert property (
    stop_det && bus_live && !start_det |=> state_q inside {ST_IDLE, ST_BUSY} && oe_n_q
  ) else $error("stop did not end transfer");

  chk_read_standby: assert property (
    stop_det && bus_live && !wr_seen_q |=> state_q == ST_IDLE ##1 standby_q
  ) else $error("read stop did not reach standby");

  chk_word_ack: assert property (
    state_q == ST_RX && word_done && !start_det && !stop_det && fifo_ready
      |=> !oe_n_q && push_q && state_q == ST_ACK ##1 !push_q
  ) else $error("received word not acknowledged");

  chk_low_only: assert property (
    sda_out == 1'b0 and (!oe_n_q |-> state_q inside {ST_ACK, ST_TX, ST_TXACK})
  ) else $error("data line driven outside a slot");

  chk_write_timed: assert property (
    state_q == ST_BUSY && write_done |=> state_q == ST_IDLE ##1 !busy_q
  ) else $error("internal write length wrong");

  chk_write_start: assert property (
    stop_det && bus_live && wr_seen_q && !start_det |=> state_q == ST_BUSY && timer_q == '0
  ) else $error("write stop did not start internal write");

  chk_settle_end: assert property (
    state_q == ST_INIT && settle_done |=> state_q == ST_IDLE ##1 standby_q
  ) else $error("settle interval did not end in standby");

  chk_settle_ignore: assert property (
    state_q == ST_INIT && !settle_done |=> state_q == ST_INIT && oe_n_q
  ) else $error("bus seen during settle interval");

  chk_select_match: assert property (
    state_q == ST_ADDR && word_done && !start_det && !stop_det
      |=> (oe_n_q == !$past(addr_match)) && (state_q == ST_IDLE) == !$past(addr_match)
  ) else $error("select word answered wrongly");

  chk_busy_ignore: assert property (
    state_q == ST_BUSY && !write_done |=> state_q == ST_BUSY && oe_n_q
  ) else $error("bus seen during internal write");

  chk_ack_release: assert property (
    state_q == ST_ACK && scl_fall && !rw_q && !start_det && !stop_det |=> oe_n_q
  ) else $error("acknowledge not released");
endmodule : eeb_front_end
`default_nettype wire

// ### dv/eeb_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module eeb_bus_master (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_oe_n_out,
  output logic sda_oe_n_out
);
  // half of the 80 ns link period in 5 ns clocks
  localparam int HALF = 8;
  initial begin
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
  endtask : hold
  // data moves only mid low phase, sampled mid high phase
  task automatic put_bit(input logic b, output logic seen);
    hold(HALF / 2);
    sda_oe_n_out <= b;
    hold(HALF / 2);
    scl_oe_n_out <= 1'b1;
    hold(HALF / 2);
    seen = sda_in;
    hold(HALF / 2);
    scl_oe_n_out <= 1'b0;
  endtask : put_bit
  task automatic start_cond();
    sda_oe_n_out <= 1'b1;
    hold(HALF / 2);
    scl_oe_n_out <= 1'b1;
    hold(HALF);
    sda_oe_n_out <= 1'b0;
    hold(HALF);
    scl_oe_n_out <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    sda_oe_n_out <= 1'b0;
    hold(HALF / 2);
    scl_oe_n_out <= 1'b1;
    hold(HALF);
    sda_oe_n_out <= 1'b1;
    hold(HALF);
  endtask : stop_cond
  // msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack);
  endtask : xfer
endmodule : eeb_bus_master
`default_nettype wire

// ### dv/eeb_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeb_front_end_tb;
  import eeb_pkg::*;
  localparam int WCYC = 50;
  localparam int LIMIT = 20000;
  // type code is arbitrary, straps 101
  localparam logic [7:0] SEL_W = 8'h9a;
  logic clock_in, reset_in, rx_ready, sda_out, sda_oe_n, rx_valid, rd_req, standby, busy;
  logic m_scl_oe_n, m_sda_oe_n, ack;
  logic [2:0] straps;
  logic [7:0] rd_data = 8'hc3;
  logic [7:0] rx;
  logic [8:0] rx_data;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  wire scl = m_scl_oe_n;
  wire sda = m_sda_oe_n & (sda_oe_n | sda_out);
  eeb_front_end #(.SETTLE_CYC(20), .WRITE_CYC(WCYC), .DEV_TYPE(4'h9)) dut_u (
    .clock_in(clock_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .addr_strap_bit2_in(straps[2]),
    .addr_strap_bit1_in(straps[1]), .addr_strap_bit0_in(straps[0]),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .rd_data_in(rd_data), .rd_req_out(rd_req), .standby_out(standby),
    .write_busy_out(busy));
  eeb_bus_master m_u (.clock_in(clock_in), .sda_in(sda), .scl_oe_n_out(m_scl_oe_n),
    .sda_oe_n_out(m_sda_oe_n));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      give_verdict();
    end
  end
  always @(posedge clock_in) begin
    if (!reset_in && sda_oe_n === 1'b0) check("sda_out", {8'h00, sda_out}, 9'h000);
    // next byte for the reader once the current one was taken
    if (rd_req === 1'b1) rd_data <= ~rd_data;
  end
  task automatic drain(input logic [8:0] exp[$]);
    int w;
    foreach (exp[i]) begin
      w = 0;
      while (rx_valid !== 1'b1 && w < 50) begin
        @(posedge clock_in);
        w++;
      end
      check("rx_word", rx_data, exp[i]);
      rx_ready <= 1'b1;
      @(posedge clock_in);
      rx_ready <= 1'b0;
      @(posedge clock_in);
    end
  endtask : drain
  task automatic t_init();
    check("standby_early", {8'h00, standby}, 9'h000);
    m_u.start_cond();
    m_u.xfer(SEL_W, 1'b1, rx, ack);
    check("ack_in_settle", {8'h00, ack}, 9'h001);
    m_u.stop_cond();
    check("standby_after_init", {8'h00, standby}, 9'h001);
  endtask : t_init
  task automatic t_write();
    int n;
    m_u.start_cond();
    m_u.xfer(SEL_W, 1'b1, rx, ack);
    check("ack_sel", {8'h00, ack}, 9'h000);
    m_u.xfer(8'h3c, 1'b1, rx, ack);
    check("ack_addr", {8'h00, ack}, 9'h000);
    m_u.xfer(8'ha5, 1'b1, rx, ack);
    check("ack_data", {8'h00, ack}, 9'h000);
    m_u.hold(6);
    check("ack_release", {8'h00, sda_oe_n}, 9'h001);
    drain('{9'h13c, 9'h0a5});
    n = 0;
    // count from before the stop so the first busy cycles are not missed
    fork
      repeat (200) begin
        @(posedge clock_in);
        if (busy === 1'b1) n++;
      end
      begin
        m_u.stop_cond();
        m_u.start_cond();
        m_u.xfer(SEL_W, 1'b1, rx, ack);
        check("ack_while_busy", {8'h00, ack}, 9'h001);
      end
    join
    check("busy_len", 9'(n), 9'(WCYC));
    check("standby_after_write", {8'h00, standby}, 9'h001);
  endtask : t_write
  task automatic t_mismatch();
    straps <= 3'b011;
    m_u.hold(6);
    m_u.start_cond();
    m_u.xfer(SEL_W, 1'b1, rx, ack);
    check("ack_mismatch", {8'h00, ack}, 9'h001);
    m_u.xfer(8'h00, 1'b1, rx, ack);
    check("ack_after_mismatch", {8'h00, ack}, 9'h001);
    check("standby_mismatch", {8'h00, standby}, 9'h001);
    straps <= 3'b101;
    m_u.stop_cond();
  endtask : t_mismatch
  // 16 entries plus the output register take words, the next is refused
  task automatic t_fill();
    logic [8:0] exp[$];
    m_u.start_cond();
    m_u.xfer(SEL_W, 1'b1, rx, ack);
    for (int i = 0; i < 18; i++) begin
      m_u.xfer(8'h40 + 8'(i), 1'b1, rx, ack);
      check("ack_fill", {8'h00, ack}, (i < 17) ? 9'h000 : 9'h001);
      if (i < 17) exp.push_back({(i == 0), 8'h40 + 8'(i)});
    end
    m_u.stop_cond();
    drain(exp);
    m_u.hold(60);
  endtask : t_fill
  task automatic t_read();
    m_u.start_cond();
    m_u.xfer(SEL_W | 8'h01, 1'b1, rx, ack);
    check("ack_rd_sel", {8'h00, ack}, 9'h000);
    m_u.xfer(8'hff, 1'b0, rx, ack);
    check("rd_byte0", {1'b0, rx}, 9'h0c3);
    m_u.xfer(8'hff, 1'b1, rx, ack);
    check("rd_byte1", {1'b0, rx}, 9'h03c);
    m_u.stop_cond();
    check("standby_after_read", {8'h00, standby}, 9'h001);
  endtask : t_read
  initial begin
    reset_in = 1'b1;
    rx_ready = 1'b0;
    straps = 3'b101;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    t_init();
    t_write();
    t_mismatch();
    t_fill();
    t_read();
    give_verdict();
  end
endmodule : eeb_front_end_tb
`default_nettype wire
